// File: logic/external_memory_bus_controller.sv
// external memory bus controller: burst sram, flash rom, nonvolatile sram
// assumes synchronous request inputs; testbench resolves the bus wires
`timescale 1ns/1ps
`default_nettype none
module external_memory_bus_controller
  import emb_pkg::*;
#(
  parameter int DEPTH     = FIFO_DEPTH,
  parameter int READ_LAT  = READ_LAT_TICKS
) (
  // clock and reset
  input  wire logic             I_CLK,
  input  wire logic             I_RST_B,
  input  wire logic             I_HOST_RST_B,
  // access requests
  input  wire logic             I_REQ_VALID,
  output var  logic             O_REQ_READY,
  input  wire logic             I_REQ_WRITE,
  input  wire logic [31:0]      I_REQ_ADDR,
  input  wire logic [31:0]      I_REQ_WDATA,
  input  wire logic [3:0]       I_REQ_BYTE_EN,
  input  wire logic [1:0]       I_REQ_BEATS_M1,
  // read data stream
  output var  logic             O_RD_VALID,
  input  wire logic             I_RD_READY,
  output var  logic [31:0]      O_RD_DATA,
  output var  logic             O_RD_PARITY_ERROR,
  // power-on configuration
  output var  logic [31:0]      O_POWER_ON_CONFIG,
  output var  logic             O_STATIC_RAM_FITTED,
  output var  logic             O_STATIC_RAM_NONVOLATILE,
  // memory pins
  output var  logic             O_MEMORY_CLOCK,
  output var  logic             O_CONTROLLER_ADDR_STROBE_N,
  output var  logic             O_BURST_ADVANCE_N,
  output var  logic [1:0]       O_MEMORY_OUTPUT_ENABLE_N,
  output var  logic [1:0]       O_BANK_WRITE_ENABLE_N,
  output var  logic [3:0]       O_BYTE_LANE_WRITE_ENABLE_N,
  output var  logic             O_NONVOLATILE_RAM_SELECT_N,
  output var  logic             O_BURST_RAM_SELECT_N,
  output var  logic             O_FLASH_ROM_SELECT_N,
  input  wire logic [31:0]      I_MUX_ADDR_DATA_BUS,
  output var  logic [31:0]      O_MUX_ADDR_DATA_BUS,
  output var  logic             O_MUX_ADDR_DATA_BUS_OE,
  input  wire logic [3:0]       I_MUX_BUS_BYTE_PARITY,
  output var  logic [3:0]       O_MUX_BUS_BYTE_PARITY,
  output var  logic             O_MUX_BUS_BYTE_PARITY_OE
);
  localparam int LW = $clog2(DEPTH) + 2;

  state_e      state_q, state_d;
  region_e     reg_q, reg_d;
  logic        mclk_q, mclk_d;
  logic        go_q, go_d;
  logic        wr_q, wr_d;
  logic [31:0] addr_q, addr_d;
  logic [31:0] wdat_q, wdat_d;
  logic [3:0]  be_q, be_d;
  logic [1:0]  beats_q, beats_d;
  logic [1:0]  beat_q, beat_d;
  logic [1:0]  wait_q, wait_d;
  logic        bank_q, bank_d;
  logic        ready_q, ready_d;
  logic        controller_addr_strobe_n_q, controller_addr_strobe_n_d;
  logic        adv_q, adv_d;
  logic [1:0]  oe_q, oe_d;
  logic [1:0]  mwe_q, mwe_d;
  logic [3:0]  bwe_q, bwe_d;
  logic        csn_q, csn_d;
  logic        csb_q, csb_d;
  logic        csf_q, csf_d;
  logic [31:0] bus_q, bus_d;
  logic        bus_oe_q, bus_oe_d;
  logic [3:0]  par_q, par_d;
  logic        push_q, push_d;
  logic [32:0] pdat_q, pdat_d;
  logic [31:0] cfg_q;
  logic        fit_q, nv_q;
  logic        tick, take, room;
  logic [LW-1:0] level;
  logic [31:0] cfg_w;
  logic [32:0] rd_word;

  // read space is reserved up front, since a burst cannot be stalled
  assign room = ({1'b0, level} + {{LW{1'b0}}, push_q} + (LW+1)'(MAX_BEATS)) <= (LW+1)'(DEPTH);

  always_comb begin
    state_d  = state_q;
    reg_d    = reg_q;
    mclk_d   = ~mclk_q;
    go_d     = go_q;
    wr_d     = wr_q;
    addr_d   = addr_q;
    wdat_d   = wdat_q;
    be_d     = be_q;
    beats_d  = beats_q;
    beat_d   = beat_q;
    wait_d   = wait_q;
    bank_d   = bank_q;
    controller_addr_strobe_n_d   = controller_addr_strobe_n_q;
    adv_d    = adv_q;
    oe_d     = oe_q;
    mwe_d    = mwe_q;
    bwe_d    = bwe_q;
    csn_d    = csn_q;
    csb_d    = csb_q;
    csf_d    = csf_q;
    bus_d    = bus_q;
    bus_oe_d = bus_oe_q;
    par_d    = par_q;
    push_d   = 1'b0;
    pdat_d   = pdat_q;
    // pins change as memory clock falls, so they settle for its rise
    tick     = mclk_q;
    take     = I_REQ_VALID && ready_q;
    if (take) begin
      go_d    = 1'b1;
      wr_d    = I_REQ_WRITE;
      addr_d  = I_REQ_ADDR;
      wdat_d  = I_REQ_WDATA;
      be_d    = I_REQ_BYTE_EN;
      reg_d   = decode_region(I_REQ_ADDR);
      // only burst ram reads burst; writes carry one word
      beats_d = (decode_region(I_REQ_ADDR) == REG_BURST && !I_REQ_WRITE) ? I_REQ_BEATS_M1 : 2'h0;
      bank_d  = I_REQ_ADDR[BANK_BIT];
    end
    if (!I_HOST_RST_B) begin
      state_d  = ST_IDLE;
      go_d     = 1'b0;
      bus_oe_d = 1'b0;
      controller_addr_strobe_n_d   = 1'b1;
      adv_d    = 1'b1;
      oe_d     = OE_NONE;
      mwe_d    = 2'b11;
      bwe_d    = BWE_NONE;
      csn_d    = 1'b1;
      csb_d    = 1'b1;
      csf_d    = 1'b1;
    end else if (tick) begin
      case (state_q)
        ST_IDLE: begin
          controller_addr_strobe_n_d = 1'b1;
          if (go_q) begin
            go_d     = 1'b0;
            state_d  = ST_ADDR;
            controller_addr_strobe_n_d   = 1'b0;
            csb_d    = (reg_q != REG_BURST);
            csf_d    = (reg_q != REG_FLASH);
            csn_d    = (reg_q != REG_NVRAM);
            bus_d    = addr_q;
            bus_oe_d = 1'b1;
            par_d    = byte_parity(addr_q);
            beat_d   = 2'h0;
          end
        end
        ST_ADDR: begin
          controller_addr_strobe_n_d = 1'b1;
          if (wr_q) begin
            state_d = ST_BEAT;
            bus_d   = wdat_q;
            par_d   = byte_parity(wdat_q);
            if (reg_q == REG_BURST) begin
              bwe_d = ~be_q;
              mwe_d = bank_q ? 2'b01 : 2'b10;
            end else begin
              bwe_d = ~(be_q & BWE_UPPER);
            end
          end else begin
            state_d  = ST_WAIT;
            bus_oe_d = 1'b0;
            wait_d   = 2'(READ_LAT - 1);
            case (reg_q)
              REG_FLASH: oe_d = OE_FLASH;
              REG_NVRAM: oe_d = OE_NVRAM;
              default:   oe_d = bank_q ? 2'b01 : 2'b10;
            endcase
          end
        end
        ST_WAIT: begin
          if (wait_q == 2'h0) begin
            state_d = ST_BEAT;
          end else begin
            wait_d = wait_q - 2'h1;
          end
        end
        ST_BEAT: begin
          if (wr_q) begin
            state_d  = ST_DESEL;
            bwe_d    = BWE_NONE;
            mwe_d    = 2'b11;
            bus_oe_d = 1'b0;
          end else begin
            push_d = 1'b1;
            pdat_d = {byte_parity(I_MUX_ADDR_DATA_BUS) != I_MUX_BUS_BYTE_PARITY,
                      I_MUX_ADDR_DATA_BUS};
            if (beat_q == beats_q) begin
              state_d = ST_DESEL;
              adv_d   = 1'b1;
              oe_d    = OE_NONE;
            end else begin
              beat_d = beat_q + 2'h1;
              adv_d  = 1'b0;
              bank_d = ~bank_q;
              oe_d   = bank_q ? 2'b10 : 2'b01;
            end
          end
        end
        ST_DESEL: begin
          // deselect cycle: strobe with every select high
          state_d = ST_IDLE;
          adv_d   = 1'b1;
          controller_addr_strobe_n_d  = 1'b0;
          csn_d   = 1'b1;
          csb_d   = 1'b1;
          csf_d   = 1'b1;
        end
        default: begin
          state_d = ST_IDLE;
        end
      endcase
    end
    // ready only on cycles whose edge is a launch edge
    ready_d = I_HOST_RST_B && (state_d == ST_IDLE) && !go_d && mclk_d && room && !take;
  end

  always_ff @(posedge I_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      state_q  <= ST_IDLE;
      reg_q    <= REG_BURST;
      mclk_q   <= 1'b0;
      go_q     <= 1'b0;
      wr_q     <= 1'b0;
      addr_q   <= '0;
      wdat_q   <= '0;
      be_q     <= '0;
      beats_q  <= '0;
      beat_q   <= '0;
      wait_q   <= '0;
      bank_q   <= 1'b0;
      ready_q  <= 1'b0;
      controller_addr_strobe_n_q   <= 1'b1;
      adv_q    <= 1'b1;
      oe_q     <= OE_NONE;
      mwe_q    <= 2'b11;
      bwe_q    <= BWE_NONE;
      csn_q    <= 1'b1;
      csb_q    <= 1'b1;
      csf_q    <= 1'b1;
      bus_q    <= '0;
      bus_oe_q <= 1'b0;
      par_q    <= '0;
      push_q   <= 1'b0;
      pdat_q   <= '0;
      cfg_q    <= CFG_RESET;
      fit_q    <= 1'b0;
      nv_q     <= 1'b0;
    end else begin
      state_q  <= state_d;
      reg_q    <= reg_d;
      mclk_q   <= mclk_d;
      go_q     <= go_d;
      wr_q     <= wr_d;
      addr_q   <= addr_d;
      wdat_q   <= wdat_d;
      be_q     <= be_d;
      beats_q  <= beats_d;
      beat_q   <= beat_d;
      wait_q   <= wait_d;
      bank_q   <= bank_d;
      ready_q  <= ready_d;
      controller_addr_strobe_n_q   <= controller_addr_strobe_n_d;
      adv_q    <= adv_d;
      oe_q     <= oe_d;
      mwe_q    <= mwe_d;
      bwe_q    <= bwe_d;
      csn_q    <= csn_d;
      csb_q    <= csb_d;
      csf_q    <= csf_d;
      bus_q    <= bus_d;
      bus_oe_q <= bus_oe_d;
      par_q    <= par_d;
      push_q   <= push_d;
      pdat_q   <= pdat_d;
      cfg_q    <= cfg_w;
      fit_q    <= cfg_w[CFG_FITTED_BIT];
      nv_q     <= cfg_w[CFG_FITTED_BIT] && cfg_w[CFG_NVRAM_BIT];
    end
  end

  emb_strap_latch u_strap (
    .i_clk        (I_CLK),
    .i_rst_b      (I_RST_B),
    .i_host_rst_b (I_HOST_RST_B),
    .i_bus        (I_MUX_ADDR_DATA_BUS),
    .o_cfg        (cfg_w)
  );

  emb_read_fifo #(
    .WIDTH (33),
    .DEPTH (DEPTH)
  ) u_fifo (
    .i_clk       (I_CLK),
    .i_rst_b     (I_RST_B),
    .i_in_valid  (push_q),
    .o_in_ready  (),
    .i_in_data   (pdat_q),
    .o_out_valid (O_RD_VALID),
    .i_out_ready (I_RD_READY),
    .o_out_data  (rd_word),
    .o_level     (level)
  );

  assign O_RD_DATA                  = rd_word[31:0];
  assign O_RD_PARITY_ERROR          = rd_word[32];
  // room check already implies fifo space, so ready stays a bare flop
  assign O_REQ_READY                = ready_q;
  assign O_POWER_ON_CONFIG          = cfg_q;
  assign O_STATIC_RAM_FITTED        = fit_q;
  assign O_STATIC_RAM_NONVOLATILE   = nv_q;
  assign O_MEMORY_CLOCK             = mclk_q;
  assign O_CONTROLLER_ADDR_STROBE_N = controller_addr_strobe_n_q;
  assign O_BURST_ADVANCE_N          = adv_q;
  assign O_MEMORY_OUTPUT_ENABLE_N   = oe_q;
  assign O_BANK_WRITE_ENABLE_N      = mwe_q;
  assign O_BYTE_LANE_WRITE_ENABLE_N = bwe_q;
  assign O_NONVOLATILE_RAM_SELECT_N = csn_q;
  assign O_BURST_RAM_SELECT_N       = csb_q;
  assign O_FLASH_ROM_SELECT_N       = csf_q;
  assign O_MUX_ADDR_DATA_BUS        = bus_q;
  assign O_MUX_ADDR_DATA_BUS_OE     = bus_oe_q;
  assign O_MUX_BUS_BYTE_PARITY      = par_q;
  assign O_MUX_BUS_BYTE_PARITY_OE   = bus_oe_q;
endmodule : external_memory_bus_controller
`default_nettype wire

// File: logic/emb_pkg.sv
// constants and types shared by the external memory bus controller
// assumes a single 20 MHz core clock; memory clock is derived from it
package emb_pkg;
  localparam int          CLK_PERIOD_NS  = 50;
  localparam int          MCLK_DIV       = 2;
  localparam int          BUS_W          = 32;
  localparam int          LANES          = 4;
  localparam int          FIFO_DEPTH     = 8;
  localparam int          MAX_BEATS      = 4;
  localparam int          READ_LAT_TICKS = 2;
  localparam int          BANK_BIT       = 2;
  localparam int          CFG_FITTED_BIT = 31;
  localparam int          CFG_NVRAM_BIT  = 30;
  // 0 selects even parity, 1 odd parity
  localparam logic        PARITY_ODD     = 1'b0;
  localparam logic [31:0] FLASH_BASE     = 32'hff00_0000;
  localparam logic [31:0] FLASH_MASK     = 32'hff00_0000;
  localparam logic [31:0] NVRAM_BASE     = 32'hfe00_0000;
  localparam logic [31:0] NVRAM_MASK     = 32'hff00_0000;
  localparam logic [31:0] CFG_RESET      = 32'h0000_0000;
  localparam logic [1:0]  OE_FLASH       = 2'b01;
  localparam logic [1:0]  OE_NVRAM       = 2'b10;
  localparam logic [1:0]  OE_NONE        = 2'b11;
  localparam logic [3:0]  BWE_NONE       = 4'hf;
  localparam logic [3:0]  BWE_UPPER      = 4'hc;

  typedef enum logic [1:0] {
    REG_BURST = 2'h0,
    REG_FLASH = 2'h1,
    REG_NVRAM = 2'h2
  } region_e;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_ADDR  = 3'b001,
    ST_WAIT  = 3'b011,
    ST_BEAT  = 3'b010,
    ST_DESEL = 3'b110
  } state_e;

  function automatic region_e decode_region(input logic [31:0] addr);
    if ((addr & FLASH_MASK) == FLASH_BASE) begin
      return REG_FLASH;
    end else if ((addr & NVRAM_MASK) == NVRAM_BASE) begin
      return REG_NVRAM;
    end
    return REG_BURST;
  endfunction : decode_region

  function automatic logic [3:0] byte_parity(input logic [31:0] word);
    logic [3:0] p;
    p = '0;
    for (int i = 0; i < 4; i++) begin
      p[i] = (^word[8*i +: 8]) ^ PARITY_ODD;
    end
    return p;
  endfunction : byte_parity
endpackage : emb_pkg

// File: logic/emb_read_fifo.sv
// read data fifo with registered output word
// assumes DEPTH is a power of two and one clock domain
`timescale 1ns/1ps
`default_nettype none
module emb_read_fifo #(
  parameter int WIDTH = 33,
  parameter int DEPTH = 8
) (
  // clock and reset
  input  wire logic             i_clk,
  input  wire logic             i_rst_b,
  // fill side
  input  wire logic             i_in_valid,
  output var  logic             o_in_ready,
  input  wire logic [WIDTH-1:0] i_in_data,
  // drain side
  output var  logic             o_out_valid,
  input  wire logic             i_out_ready,
  output var  logic [WIDTH-1:0] o_out_data,
  // occupancy including output word
  output var  logic [$clog2(DEPTH)+1:0] o_level
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0]    wr_q, wr_d, rd_q, rd_d;
  logic [AW:0]      cnt_q, cnt_d;
  logic             ov_q, ov_d;
  logic [WIDTH-1:0] od_q, od_d;
  logic             push, load;

  always_comb begin
    push = i_in_valid && (cnt_q != DEPTH[AW:0]);
    load = (cnt_q != '0) && (!ov_q || i_out_ready);
    wr_d = push ? wr_q + 1'b1 : wr_q;
    rd_d = load ? rd_q + 1'b1 : rd_q;
    cnt_d = cnt_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, load};
    ov_d = ov_q;
    od_d = od_q;
    if (load) begin
      ov_d = 1'b1;
      od_d = mem_q[rd_q];
    end else if (i_out_ready) begin
      ov_d = 1'b0;
    end
  end

  always_ff @(posedge i_clk) begin
    if (push) begin
      mem_q[wr_q] <= i_in_data;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
      ov_q  <= 1'b0;
      od_q  <= '0;
    end else begin
      wr_q  <= wr_d;
      rd_q  <= rd_d;
      cnt_q <= cnt_d;
      ov_q  <= ov_d;
      od_q  <= od_d;
    end
  end

  assign o_in_ready  = (cnt_q != DEPTH[AW:0]);
  assign o_out_valid = ov_q;
  assign o_out_data  = od_q;
  assign o_level     = {1'b0, cnt_q} + {{(AW+1){1'b0}}, ov_q};
endmodule : emb_read_fifo
`default_nettype wire

// File: logic/emb_strap_latch.sv
// power-on configuration capture from the shared bus
// assumes the controller keeps the bus released while host reset is low
`timescale 1ns/1ps
`default_nettype none
module emb_strap_latch
  import emb_pkg::*;
(
  // clock and reset
  input  wire logic             i_clk,
  input  wire logic             i_rst_b,
  // sense inputs
  input  wire logic             i_host_rst_b,
  input  wire logic [BUS_W-1:0] i_bus,
  // captured configuration
  output var  logic [BUS_W-1:0] o_cfg
);
  logic [BUS_W-1:0] smp_q, smp_d, cfg_q, cfg_d;
  logic             hr_q;

  always_comb begin
    smp_d = smp_q;
    cfg_d = cfg_q;
    if (!i_host_rst_b) begin
      smp_d = i_bus;
    end
    if (i_host_rst_b && !hr_q) begin
      cfg_d = smp_q;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      smp_q <= CFG_RESET;
      cfg_q <= CFG_RESET;
      hr_q  <= 1'b0;
    end else begin
      smp_q <= smp_d;
      cfg_q <= cfg_d;
      hr_q  <= i_host_rst_b;
    end
  end

  assign o_cfg = cfg_q;
endmodule : emb_strap_latch
`default_nettype wire

// File: test/emb_bus_checker_sva.sv
// checker for the memory pins of the external bus controller
// assumes it is bound to the controller top and sees only its ports
`timescale 1ns/1ps
`default_nettype none
module emb_bus_checker (
  // clock and resets
  input wire logic        I_CLK,
  input wire logic        I_RST_B,
  input wire logic        I_HOST_RST_B,
  // request side
  input wire logic        O_REQ_READY,
  // memory pins
  input wire logic        O_MEMORY_CLOCK,
  input wire logic        O_CONTROLLER_ADDR_STROBE_N,
  input wire logic        O_BURST_ADVANCE_N,
  input wire logic [1:0]  O_MEMORY_OUTPUT_ENABLE_N,
  input wire logic [1:0]  O_BANK_WRITE_ENABLE_N,
  input wire logic [3:0]  O_BYTE_LANE_WRITE_ENABLE_N,
  input wire logic        O_NONVOLATILE_RAM_SELECT_N,
  input wire logic        O_BURST_RAM_SELECT_N,
  input wire logic        O_FLASH_ROM_SELECT_N,
  input wire logic [31:0] O_MUX_ADDR_DATA_BUS,
  input wire logic        O_MUX_ADDR_DATA_BUS_OE,
  input wire logic [3:0]  O_MUX_BUS_BYTE_PARITY,
  input wire logic        O_MUX_BUS_BYTE_PARITY_OE,
  // configuration
  input wire logic [31:0] O_POWER_ON_CONFIG,
  input wire logic        O_STATIC_RAM_FITTED,
  input wire logic        O_STATIC_RAM_NONVOLATILE
);
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (!I_RST_B);
  wire logic [2:0]  sel_n = {O_NONVOLATILE_RAM_SELECT_N, O_BURST_RAM_SELECT_N, O_FLASH_ROM_SELECT_N};
  wire logic [31:0] b     = O_MUX_ADDR_DATA_BUS;
  // strobe lasts one memory clock period
  sequence s_strobe_end;
    !O_CONTROLLER_ADDR_STROBE_N ##1 O_CONTROLLER_ADDR_STROBE_N;
  endsequence
  sequence s_mclk_cycle;
    !O_MEMORY_CLOCK ##1 O_MEMORY_CLOCK;
  endsequence
  AST_MCLK_TOGGLE: assert property (O_MEMORY_CLOCK |=> s_mclk_cycle)
    else $error("memory clock not toggling");
  AST_STROBE_LEN: assert property ($fell(O_CONTROLLER_ADDR_STROBE_N) |-> ##1 s_strobe_end)
    else $error("address strobe width wrong");
  AST_ADVANCE_SEL: assert property (!O_BURST_ADVANCE_N |-> !O_BURST_RAM_SELECT_N)
    else $error("advance without burst select");
  AST_PARITY_OUT: assert property (O_MUX_BUS_BYTE_PARITY_OE |-> O_MUX_BUS_BYTE_PARITY ==
    {^b[31:24], ^b[23:16], ^b[15:8], ^b[7:0]}) else $error("driven parity wrong");
  AST_PARITY_OE: assert property (O_MUX_BUS_BYTE_PARITY_OE == O_MUX_ADDR_DATA_BUS_OE)
    else $error("parity enable differs from bus enable");
  AST_FLASH_OE: assert property (!O_FLASH_ROM_SELECT_N && O_MEMORY_OUTPUT_ENABLE_N != 2'b11
    |-> O_MEMORY_OUTPUT_ENABLE_N == 2'b01) else $error("flash read uses wrong enable");
  AST_NVRAM_OE: assert property (!O_NONVOLATILE_RAM_SELECT_N && O_MEMORY_OUTPUT_ENABLE_N != 2'b11
    |-> O_MEMORY_OUTPUT_ENABLE_N == 2'b10) else $error("nvram read uses wrong enable");
  AST_BANK_WE: assert property (O_BANK_WRITE_ENABLE_N != 2'b11
    |-> $onehot(~O_BANK_WRITE_ENABLE_N) && !O_BURST_RAM_SELECT_N) else $error("bank write enable wrong");
  AST_UPPER_LANES: assert property (sel_n[2] == 1'b0 || sel_n[0] == 1'b0
    |-> O_BYTE_LANE_WRITE_ENABLE_N[1:0] == 2'b11 && O_BANK_WRITE_ENABLE_N == 2'b11)
    else $error("low lanes written on flash or nvram");
  AST_ONE_SELECT: assert property ($onehot0(~sel_n))
    else $error("more than one select");
  AST_ADDR_SELECT: assert property (!O_CONTROLLER_ADDR_STROBE_N && O_MUX_ADDR_DATA_BUS_OE |-> $onehot(~sel_n))
    else $error("address phase without one select");
  AST_HOST_RELEASE: assert property (!I_HOST_RST_B [*3] |-> !O_MUX_ADDR_DATA_BUS_OE && sel_n == 3'b111)
    else $error("bus driven in host reset");
  AST_STRAP_FLAGS: assert property (O_STATIC_RAM_FITTED == O_POWER_ON_CONFIG[31] &&
    O_STATIC_RAM_NONVOLATILE == (O_POWER_ON_CONFIG[31] & O_POWER_ON_CONFIG[30])) else $error("strap flags wrong");
  AST_READ_RELEASE: assert property (O_MEMORY_OUTPUT_ENABLE_N != 2'b11 |-> !O_MUX_ADDR_DATA_BUS_OE)
    else $error("bus driven during read");
  AST_READY_PULSE: assert property (O_REQ_READY |-> O_MEMORY_CLOCK ##1 !O_REQ_READY)
    else $error("ready not a single high-phase pulse");
endmodule : emb_bus_checker
`default_nettype wire

// File: test/emb_mem_model.sv
// partner model: burst rams, flash and nvram as one word store
// assumes the bench resolves the shared bus and its pull levels
`timescale 1ns/1ps
`default_nettype none
module emb_mem_model (
  // memory pins
  input  wire logic        i_mclk,
  input  wire logic        i_strobe_n,
  input  wire logic        i_adv_n,
  input  wire logic [1:0]  i_oe_n,
  input  wire logic [3:0]  i_bwe_n,
  input  wire logic [2:0]  i_sel_n,
  input  wire logic        i_bus_oe,
  input  wire logic [31:0] i_bus,
  // fault control
  input  wire logic        i_bad_par,
  // read drive
  output logic [31:0]      o_bus,
  output logic [3:0]       o_par,
  output logic             o_oe
);
  logic [31:0] mem [logic [31:0]];
  logic [31:0] addr_q = '0;
  logic [31:0] word;
  // unwritten words read a pattern tied to the address
  function automatic logic [31:0] peek(logic [31:0] a);
    return mem.exists(a) ? mem[a] : a ^ 32'h5a5a_a5a5;
  endfunction : peek
  always @(posedge i_mclk) begin
    if (!i_strobe_n && i_bus_oe && i_sel_n != 3'b111) begin
      addr_q <= {i_bus[31:2], 2'b00};
    end else if (!i_adv_n) begin
      addr_q <= addr_q + 32'h4;
    end
    if (i_bus_oe && i_strobe_n && i_bwe_n != 4'hf) begin
      word = peek(addr_q);
      for (int i = 0; i < 4; i++) begin
        if (!i_bwe_n[i]) word[8*i +: 8] = i_bus[8*i +: 8];
      end
      mem[addr_q] = word;
    end
  end
  // word is listed so that a write to the current address refreshes the read
  always @(addr_q, word, i_oe_n, i_sel_n, i_bad_par) begin
    o_oe  = i_oe_n != 2'b11 && i_sel_n != 3'b111;
    o_bus = peek(addr_q);
    o_par = {^o_bus[31:24], ^o_bus[23:16], ^o_bus[15:8], ^o_bus[7:0] ^ i_bad_par};
  end
endmodule : emb_mem_model
`default_nettype wire

// File: test/tb_external_memory_bus_controller.sv
// testbench for the external memory bus controller
// assumes the design defaults: eight word fifo, even parity
`timescale 1ns/1ps
`default_nettype none
module tb_external_memory_bus_controller;
  logic        clk, rst_b, host_rst_b, req_valid, req_write, rd_ready, bad_par;
  logic        req_ready, rd_valid, rd_perr, fitted, nonvol, mclk, strobe_n, adv_n;
  logic        nv_sel_n, br_sel_n, fl_sel_n, bus_oe, par_oe, mem_oe;
  logic [31:0] req_addr, req_wdata, strap, bus_o, bus, mem_bus, cfg, rd_data;
  logic [3:0]  req_be, par_o, par, mem_par, bwe_n;
  logic [1:0]  req_bm1, oe_n, bank_we_n;
  int          failures, checks;
  // released lines: pull-ups from straps on the bus, pull-ups on parity
  assign bus = bus_oe ? bus_o : mem_oe ? mem_bus : strap;
  assign par = par_oe ? par_o : mem_oe ? mem_par : 4'hf;
  external_memory_bus_controller u_dut (
    .I_CLK(clk), .I_RST_B(rst_b), .I_HOST_RST_B(host_rst_b),
    .I_REQ_VALID(req_valid), .O_REQ_READY(req_ready), .I_REQ_WRITE(req_write), .I_REQ_ADDR(req_addr),
    .I_REQ_WDATA(req_wdata), .I_REQ_BYTE_EN(req_be), .I_REQ_BEATS_M1(req_bm1),
    .O_RD_VALID(rd_valid), .I_RD_READY(rd_ready), .O_RD_DATA(rd_data), .O_RD_PARITY_ERROR(rd_perr),
    .O_POWER_ON_CONFIG(cfg), .O_STATIC_RAM_FITTED(fitted), .O_STATIC_RAM_NONVOLATILE(nonvol),
    .O_MEMORY_CLOCK(mclk), .O_CONTROLLER_ADDR_STROBE_N(strobe_n), .O_BURST_ADVANCE_N(adv_n),
    .O_MEMORY_OUTPUT_ENABLE_N(oe_n), .O_BANK_WRITE_ENABLE_N(bank_we_n), .O_BYTE_LANE_WRITE_ENABLE_N(bwe_n),
    .O_NONVOLATILE_RAM_SELECT_N(nv_sel_n), .O_BURST_RAM_SELECT_N(br_sel_n), .O_FLASH_ROM_SELECT_N(fl_sel_n),
    .I_MUX_ADDR_DATA_BUS(bus), .O_MUX_ADDR_DATA_BUS(bus_o), .O_MUX_ADDR_DATA_BUS_OE(bus_oe),
    .I_MUX_BUS_BYTE_PARITY(par), .O_MUX_BUS_BYTE_PARITY(par_o), .O_MUX_BUS_BYTE_PARITY_OE(par_oe));
  emb_mem_model u_mem (
    .i_mclk(mclk), .i_strobe_n(strobe_n), .i_adv_n(adv_n), .i_oe_n(oe_n), .i_bwe_n(bwe_n),
    .i_sel_n({nv_sel_n, br_sel_n, fl_sel_n}), .i_bus_oe(bus_oe), .i_bus(bus), .i_bad_par(bad_par),
    .o_bus(mem_bus), .o_par(mem_par), .o_oe(mem_oe));
  function automatic logic [31:0] def(logic [31:0] a);
    return {a[31:2], 2'b00} ^ 32'h5a5a_a5a5;
  endfunction : def
  task automatic chk(string n, logic [31:0] exp, logic [31:0] got);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", n, exp, got);
    end
  endtask : chk
  task automatic end_sim();
    if (failures == 0 && checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : end_sim
  // request held until the edge that samples ready high
  task automatic req(logic w, logic [31:0] a, logic [31:0] d, logic [3:0] be, logic [1:0] m1);
    int n;
    n = 0;
    @(posedge clk);
    req_valid <= 1'b1;
    req_write <= w;
    req_addr  <= a;
    req_wdata <= d;
    req_be    <= be;
    req_bm1   <= m1;
    do begin
      @(posedge clk);
      n++;
    end while (req_ready !== 1'b1 && n < 100);
    if (n >= 100) chk("request taken", 1, 0);
    req_valid <= 1'b0;
  endtask : req
  task automatic get(logic [31:0] exp, logic pe);
    int n;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (!(rd_valid === 1'b1 && rd_ready === 1'b1) && n < 200);
    chk("read taken", 1, rd_valid & rd_ready);
    chk("read word", exp, rd_data);
    chk("parity error flag", pe, rd_perr);
  endtask : get
  task automatic t_straps();
    repeat (4) @(posedge clk);
    host_rst_b <= 1'b1;
    repeat (3) @(posedge clk);
    chk("config", 32'hc000_0000, cfg);
    chk("fitted nonvolatile", 2'b11, {fitted, nonvol});
    host_rst_b <= 1'b0;
    strap      <= 32'h8000_0000;
    repeat (4) @(posedge clk);
    host_rst_b <= 1'b1;
    repeat (3) @(posedge clk);
    strap      <= '0;
    chk("config", 32'h8000_0000, cfg);
    chk("fitted nonvolatile", 2'b10, {fitted, nonvol});
  endtask : t_straps
  // burst ram, flash window, nvram window: partial write then read back
  task automatic t_regions();
    logic [31:0] a [3] = '{32'h0000_0104, 32'hff00_0010, 32'hfe00_0020};
    logic [3:0]  b [3] = '{4'h3, 4'hc, 4'hc};
    logic [31:0] m;
    for (int i = 0; i < 3; i++) begin
      m = {{8{b[i][3]}}, {8{b[i][2]}}, {8{b[i][1]}}, {8{b[i][0]}}};
      req(1'b1, a[i], 32'h1122_3344, b[i], 2'd0);
      req(1'b0, a[i], 32'h0, 4'h0, 2'd0);
      get((def(a[i]) & ~m) | (32'h1122_3344 & m), 1'b0);
    end
  endtask : t_regions
  // two four-beat bursts fill the fifo while the drain side stalls
  task automatic t_fill();
    int n;
    n = 0;
    rd_ready <= 1'b0;
    req(1'b0, 32'h200, 32'h0, 4'h0, 2'd3);
    req(1'b0, 32'h304, 32'h0, 4'h0, 2'd3);
    @(posedge clk);
    req_valid <= 1'b1;
    repeat (80) begin
      @(posedge clk);
      n += int'(req_ready === 1'b1);
    end
    req_valid <= 1'b0;
    chk("requests taken while full", 0, n);
    rd_ready <= 1'b1;
    for (int i = 0; i < 8; i++) get(def(32'h200 + 32'h104 * (i / 4) + 4 * (i % 4)), 1'b0);
    repeat (4) @(posedge clk);
    chk("fifo empty", 0, rd_valid);
  endtask : t_fill
  task automatic t_parity();
    bad_par <= 1'b1;
    req(1'b0, 32'h400, 32'h0, 4'h0, 2'd0);
    get(def(32'h400), 1'b1);
    bad_par <= 1'b0;
  endtask : t_parity
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // all scenarios take well under 3000 cycles
  initial begin
    repeat (20000) @(posedge clk);
    failures++;
    end_sim();
  end
  initial begin
    failures   = 0;
    checks     = 0;
    rst_b      = 1'b0;
    host_rst_b = 1'b0;
    req_valid  = 1'b0;
    req_write  = 1'b0;
    req_addr   = '0;
    req_wdata  = '0;
    req_be     = '0;
    req_bm1    = '0;
    rd_ready   = 1'b1;
    bad_par    = 1'b0;
    strap      = 32'hc000_0000;
    repeat (12) @(posedge clk);
    rst_b <= 1'b1;
    t_straps();
    t_regions();
    t_fill();
    t_parity();
    end_sim();
  end
endmodule : tb_external_memory_bus_controller
bind external_memory_bus_controller emb_bus_checker u_chk (
  .I_CLK(I_CLK), .I_RST_B(I_RST_B), .I_HOST_RST_B(I_HOST_RST_B), .O_REQ_READY(O_REQ_READY),
  .O_MEMORY_CLOCK(O_MEMORY_CLOCK), .O_CONTROLLER_ADDR_STROBE_N(O_CONTROLLER_ADDR_STROBE_N),
  .O_BURST_ADVANCE_N(O_BURST_ADVANCE_N), .O_MEMORY_OUTPUT_ENABLE_N(O_MEMORY_OUTPUT_ENABLE_N),
  .O_BANK_WRITE_ENABLE_N(O_BANK_WRITE_ENABLE_N), .O_BYTE_LANE_WRITE_ENABLE_N(O_BYTE_LANE_WRITE_ENABLE_N),
  .O_NONVOLATILE_RAM_SELECT_N(O_NONVOLATILE_RAM_SELECT_N), .O_BURST_RAM_SELECT_N(O_BURST_RAM_SELECT_N),
  .O_FLASH_ROM_SELECT_N(O_FLASH_ROM_SELECT_N), .O_MUX_ADDR_DATA_BUS(O_MUX_ADDR_DATA_BUS),
  .O_MUX_ADDR_DATA_BUS_OE(O_MUX_ADDR_DATA_BUS_OE), .O_MUX_BUS_BYTE_PARITY(O_MUX_BUS_BYTE_PARITY),
  .O_MUX_BUS_BYTE_PARITY_OE(O_MUX_BUS_BYTE_PARITY_OE), .O_POWER_ON_CONFIG(O_POWER_ON_CONFIG),
  .O_STATIC_RAM_FITTED(O_STATIC_RAM_FITTED), .O_STATIC_RAM_NONVOLATILE(O_STATIC_RAM_NONVOLATILE));
`default_nettype wire
